//--- core/ictl_map.svh
`ifndef ICTL_MAP_SVH
`define ICTL_MAP_SVH

// Address window
`define ICTL_BASE        32'hFFFFF000
`define ICTL_WIN_MSB     11

// Register byte offsets inside the window
`define ICTL_OFF_SMR     12'h000
`define ICTL_OFF_SVR     12'h080
`define ICTL_OFF_IVR     12'h100
`define ICTL_OFF_FVR     12'h104
`define ICTL_OFF_ISR     12'h108
`define ICTL_OFF_IPR     12'h10C
`define ICTL_OFF_IMR     12'h110
`define ICTL_OFF_CISR    12'h114
`define ICTL_OFF_IECR    12'h120
`define ICTL_OFF_IDCR    12'h124
`define ICTL_OFF_ICCR    12'h128
`define ICTL_OFF_ISCR    12'h12C
`define ICTL_OFF_EOICR   12'h130
`define ICTL_OFF_SPU     12'h134
`define ICTL_OFF_DCR     12'h138
`define ICTL_OFF_FFER    12'h140
`define ICTL_OFF_FFDR    12'h144
`define ICTL_OFF_FFSR    12'h148
`define ICTL_OFF_EVS     12'h150
`define ICTL_OFF_EVM     12'h154
`define ICTL_OFF_WPMR    12'h1E4
`define ICTL_OFF_WPSR    12'h1E8

// Field positions
`define ICTL_PRIO_MSB    2
`define ICTL_PRIO_LSB    0
`define ICTL_TRIG_MSB    6
`define ICTL_TRIG_LSB    5
`define ICTL_SMR_MASK    32'h00000067
`define ICTL_DCR_PROT    0
`define ICTL_DCR_GMSK    1
`define ICTL_DCR_MASK    32'h00000003
`define ICTL_WPMR_EN     0
`define ICTL_WPSR_FLAG   0
`define ICTL_WPSR_SRC_L  8
`define ICTL_WPSR_SRC_M  19
`define ICTL_EV_LOCK     0
`define ICTL_EV_SPUR     1
`define ICTL_EV_MASK     32'h00000003

// Reset values
`define ICTL_RST_WORD    32'h00000000
`define ICTL_EXT_DEF     32'h00000001

`endif

//--- core/ictl_pkg.sv
package ictl_pkg;
    // Trigger codes in mode-register order
    typedef enum logic [1:0] {
        ICTL_TRIG_LVL_DEF,
        ICTL_TRIG_EDGE_DEF,
        ICTL_LEVEL_ACTIVE_HIGH,
        ICTL_EDGE_RISING
    } ictl_trig_t;
    typedef logic [2:0]  ictl_prio_t;
    typedef logic [4:0]  ictl_src_t;
    typedef logic [31:0] ictl_word_t;
endpackage : ictl_pkg

//--- core/ictl_top.sv
// Contract
// - Lock on: writes to mode, vector, spurious and debug registers are ignored.
// - Locked write attempt sets violation flag and records the target offset.
// - Reading the lock status register clears the violation flag.
// - Registers decode in one 4 KB window at base 0xFFFFF000.
// - 32 mode registers at 0x00..0x7C, read-write, reset zero.
// - 32 vector registers at 0x80..0xFC, read-write, reset zero.
// - External pending follows input level; others reset not pending.
// - Priority field bits 2:0, 0 lowest, 7 highest.
// - Fast source priority field is ignored.
// - Code 0: internal high level, external low level.
// - Code 1: internal rising edge, external falling edge.
// - Code 2: high level for all sources.
// - Code 3: rising edge for all; trigger field bits 6:5.
// - Internal sources have fixed active polarity.
// - Current vector read gives vector of highest-priority pending source, else spurious.
// - Fast vector read gives vector zero, else spurious.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ictl_map.svh"

module ictl_top #(
    parameter logic [31:0] BASE_ADDR = `ICTL_BASE,
    parameter logic [31:0] EXT_SRC   = `ICTL_EXT_DEF   // Which sources come from pins
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic [31:0] src_in,
    output var  logic        irq_n,
    output var  logic        fiq_n,
    output var  logic        irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [31:0]        smr [32];
    logic [31:0]        svr [32];
    logic [31:0]        next_smr [32];
    logic [31:0]        next_svr [32];
    logic [31:0]        spu, next_spu;
    logic [31:0]        dcr, next_dcr;
    logic               lock, next_lock;
    logic               wp_flag, next_wp_flag;
    logic [11:0]        wp_src, next_wp_src;
    logic [31:0]        ev_stat, next_ev_stat;
    logic [31:0]        ev_mask, next_ev_mask;
    logic [31:0]        enabled, next_enabled;
    logic [31:0]        forced, next_forced;
    logic [31:0]        edge_pend, next_edge_pend;
    logic [31:0]        src_q, src_d;
    ictl_pkg::ictl_src_t cur_id, next_cur_id;
    logic [31:0]        next_prdata;
    logic               next_pready;
    logic               next_irq_n, next_fiq_n, next_irq_out;

    logic [11:0]        off;
    logic               in_win, wr, rd, prot_hit, viol, ack;
    logic [31:0]        inv, is_edge, act, hit, pend, cand;
    ictl_pkg::ictl_src_t sel;
    logic               found, fast_req;
    logic [31:0]        ivr_val, fvr_val, rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign off    = paddr[`ICTL_WIN_MSB:0];
    assign in_win = (paddr[31:`ICTL_WIN_MSB+1] == BASE_ADDR[31:`ICTL_WIN_MSB+1]);
    assign wr     = psel && penable && pready && pwrite && in_win;
    assign rd     = psel && penable && pready && !pwrite && in_win;
    // Protected set: both arrays, spurious vector and debug control
    assign prot_hit = (off < `ICTL_OFF_IVR) || (off == `ICTL_OFF_SPU)
                      || (off == `ICTL_OFF_DCR);
    assign viol     = wr && lock && prot_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Source conditioning: polarity and edge selection per source
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            // Pins may invert; internal lines are always active high
            inv[i]     = EXT_SRC[i] && !smr[i][`ICTL_TRIG_MSB];
            is_edge[i] = smr[i][`ICTL_TRIG_LSB];
            act[i]     = src_q[i] ^ inv[i];
            hit[i]     = act[i] && !(src_d[i] ^ inv[i]);
            pend[i]    = is_edge[i] ? edge_pend[i] : act[i];
        end
    end

    // Priority pick over normal sources; source 0 never competes
    always_comb begin
        cand  = pend & enabled & ~forced;
        sel   = 5'h00;
        found = 1'b0;
        for (int i = 1; i < 32; i++) begin
            if (cand[i] && (!found
                || smr[i][`ICTL_PRIO_MSB:0] > smr[sel][`ICTL_PRIO_MSB:0])) begin
                sel   = 5'(i);
                found = 1'b1;
            end
        end
        fast_req = (pend[0] && enabled[0]) || |(pend & enabled & forced);
        ivr_val  = found ? svr[sel] : spu;
        fvr_val  = fast_req ? svr[0] : spu;
    end

    // Acknowledge: on read normally, on write in protect mode
    assign ack = (off == `ICTL_OFF_IVR) && found
                 && (dcr[`ICTL_DCR_PROT] ? wr : rd);

    ////////////////////////////////////////////////////////////////////////////
    // Read mux, sampled in the setup phase
    always_comb begin
        rdata = `ICTL_RST_WORD;
        if (in_win) begin
            if (off < `ICTL_OFF_SVR) begin
                rdata = smr[off[6:2]];
            end else if (off < `ICTL_OFF_IVR) begin
                rdata = svr[off[6:2]];
            end else begin
                unique case (off)
                    `ICTL_OFF_IVR:  rdata = ivr_val;
                    `ICTL_OFF_FVR:  rdata = fvr_val;
                    `ICTL_OFF_ISR:  rdata = {27'h0, cur_id};
                    `ICTL_OFF_IPR:  rdata = pend;
                    `ICTL_OFF_IMR:  rdata = enabled;
                    `ICTL_OFF_CISR: rdata = {30'h0, !irq_n, !fiq_n};
                    `ICTL_OFF_SPU:  rdata = spu;
                    `ICTL_OFF_DCR:  rdata = dcr;
                    `ICTL_OFF_FFSR: rdata = forced;
                    `ICTL_OFF_EVS:  rdata = ev_stat;
                    `ICTL_OFF_EVM:  rdata = ev_mask;
                    `ICTL_OFF_WPMR: rdata = {31'h0, lock};
                    `ICTL_OFF_WPSR: rdata = {12'h000, wp_src, 7'h00, wp_flag};
                    default:        rdata = `ICTL_RST_WORD;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_comb begin
        next_smr  = smr;
        next_svr  = svr;
        next_spu  = spu;
        next_dcr  = dcr;
        next_lock = lock;
        next_ev_mask = ev_mask;
        // Locked writes leave every protected register untouched
        if (wr && !lock) begin
            if (off < `ICTL_OFF_SVR) begin
                next_smr[off[6:2]] = pwdata & `ICTL_SMR_MASK;
            end else if (off < `ICTL_OFF_IVR) begin
                next_svr[off[6:2]] = pwdata;
            end else if (off == `ICTL_OFF_SPU) begin
                next_spu = pwdata;
            end else if (off == `ICTL_OFF_DCR) begin
                next_dcr = pwdata & `ICTL_DCR_MASK;
            end
        end
        if (wr && off == `ICTL_OFF_WPMR) begin
            next_lock = pwdata[`ICTL_WPMR_EN];
        end
        if (wr && off == `ICTL_OFF_EVM) begin
            next_ev_mask = pwdata & `ICTL_EV_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 32; i++) begin
                smr[i] <= `ICTL_RST_WORD;
                svr[i] <= `ICTL_RST_WORD;
            end
            spu     <= `ICTL_RST_WORD;
            dcr     <= `ICTL_RST_WORD;
            lock    <= 1'b0;
            ev_mask <= `ICTL_RST_WORD;
        end else begin
            smr     <= next_smr;
            svr     <= next_svr;
            spu     <= next_spu;
            dcr     <= next_dcr;
            lock    <= next_lock;
            ev_mask <= next_ev_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source state: enables, redirection, edge latches, current source
    always_comb begin
        next_enabled   = enabled;
        next_forced    = forced;
        next_cur_id    = cur_id;
        next_edge_pend = edge_pend;
        if (wr && off == `ICTL_OFF_IECR) next_enabled = enabled | pwdata;
        if (wr && off == `ICTL_OFF_IDCR) next_enabled = enabled & ~pwdata;
        // Source 0 is already fast; redirecting it means nothing
        if (wr && off == `ICTL_OFF_FFER) next_forced = (forced | pwdata) & 32'hFFFFFFFE;
        if (wr && off == `ICTL_OFF_FFDR) next_forced = forced & ~pwdata;
        if (ack) next_cur_id = sel;
        // Clears first, then sets and fresh edges, so an event is never lost
        if (wr && off == `ICTL_OFF_ICCR) next_edge_pend = next_edge_pend & ~pwdata;
        if (ack) next_edge_pend[sel] = 1'b0;
        if (rd && off == `ICTL_OFF_FVR) next_edge_pend[0] = 1'b0;
        next_edge_pend = next_edge_pend | (hit & is_edge);
        if (wr && off == `ICTL_OFF_ISCR) next_edge_pend = next_edge_pend | pwdata;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enabled   <= `ICTL_RST_WORD;
            forced    <= `ICTL_RST_WORD;
            cur_id    <= 5'h00;
            edge_pend <= `ICTL_RST_WORD;
            src_q     <= `ICTL_RST_WORD;
            src_d     <= `ICTL_RST_WORD;
        end else begin
            enabled   <= next_enabled;
            forced    <= next_forced;
            cur_id    <= next_cur_id;
            edge_pend <= next_edge_pend;
            src_q     <= src_in;
            src_d     <= src_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lock status and event flags
    always_comb begin
        next_wp_flag = wp_flag;
        next_wp_src  = wp_src;
        next_ev_stat = ev_stat;
        // Only the bits the reader actually saw are cleared
        if (rd && off == `ICTL_OFF_WPSR && prdata[`ICTL_WPSR_FLAG]) begin
            next_wp_flag = 1'b0;
        end
        if (rd && off == `ICTL_OFF_EVS) begin
            next_ev_stat = ev_stat & ~prdata;
        end
        if (viol) begin
            next_wp_flag = 1'b1;
            next_wp_src  = off;
            next_ev_stat[`ICTL_EV_LOCK] = 1'b1;
        end
        if (rd && off == `ICTL_OFF_IVR && !found) begin
            next_ev_stat[`ICTL_EV_SPUR] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_flag <= 1'b0;
            wp_src  <= 12'h000;
            ev_stat <= `ICTL_RST_WORD;
        end else begin
            wp_flag <= next_wp_flag;
            wp_src  <= next_wp_src;
            ev_stat <= next_ev_stat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer and core lines; prdata registered in the setup phase, so no wait state
    always_comb begin
        next_pready  = psel && !penable;
        next_prdata  = (psel && !penable) ? rdata : prdata;
        // General mask forces both lines inactive
        next_irq_n   = !(found && !dcr[`ICTL_DCR_GMSK]);
        next_fiq_n   = !(fast_req && !dcr[`ICTL_DCR_GMSK]);
        next_irq_out = |(next_ev_stat & ev_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= `ICTL_RST_WORD;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq_n   <= 1'b1;
            fiq_n   <= 1'b1;
            irq_out <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= 1'b0;
            irq_n   <= next_irq_n;
            fiq_n   <= next_fiq_n;
            irq_out <= next_irq_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking ast_clk @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_LOCK_HOLD: assert property (
        wr && lock && off == `ICTL_OFF_SVR |=> svr[0] == $past(svr[0]))
        else $error("locked vector write changed the register");
    AST_VIOL_SET: assert property (
        viol |=> wp_flag && wp_src == $past(off))
        else $error("violation not recorded");
    AST_RD_CLEAR: assert property (
        rd && off == `ICTL_OFF_WPSR && !viol |=> !wp_flag)
        else $error("status read left violation flag set");
    AST_OUT_WIN: assert property (
        psel && !penable && !in_win |=> prdata == `ICTL_RST_WORD)
        else $error("read outside window returned data");
    AST_SMR_WRITE: assert property (
        wr && !lock && off == `ICTL_OFF_SMR
        |=> smr[0] == ($past(pwdata) & `ICTL_SMR_MASK))
        else $error("mode register write lost");
    AST_SVR_READ: assert property (
        psel && !penable && in_win && off == `ICTL_OFF_SVR
        |=> prdata == $past(svr[0]))
        else $error("vector register readback wrong");
    AST_LEVEL_FOLLOW: assert property (
        !is_edge[0] |-> pend[0] == (src_q[0] ^ inv[0]))
        else $error("level source pending does not follow input");
    AST_PRIO_ORDER: assert property (
        cand[2] && cand[3] && smr[3][`ICTL_PRIO_MSB:0] > smr[2][`ICTL_PRIO_MSB:0]
        |-> sel != 5'h02)
        else $error("lower priority source selected");
    AST_FAST_EXCL: assert property (
        found |-> sel != 5'h00)
        else $error("fast source entered priority pick");
    AST_EXT_FALL: assert property (
        EXT_SRC[0] && smr[0][`ICTL_TRIG_MSB:`ICTL_TRIG_LSB] == 2'h1
        && $fell(src_q[0]) |=> edge_pend[0])
        else $error("external falling edge missed");
    AST_INT_FIXED: assert property (
        !EXT_SRC[1] |-> !inv[1])
        else $error("internal source polarity inverted");
    AST_IVR_READ: assert property (
        psel && !penable && in_win && off == `ICTL_OFF_IVR
        |=> prdata == $past(found ? svr[sel] : spu))
        else $error("current vector readback wrong");
    AST_FVR_READ: assert property (
        psel && !penable && in_win && off == `ICTL_OFF_FVR
        |=> prdata == $past(fast_req ? svr[0] : spu))
        else $error("fast vector readback wrong");
    AST_RESERVED: assert property (
        psel && !penable && in_win && off == 12'h118 |=> prdata == `ICTL_RST_WORD)
        else $error("reserved offset read nonzero");
    AST_LOCK_SMR: assert property (
        wr && lock && off < `ICTL_OFF_SVR
        |=> smr[$past(off[6:2])] == $past(smr[off[6:2]]))
        else $error("locked mode write changed the register");
    AST_LOCK_CFG: assert property (
        wr && lock |=> spu == $past(spu) && dcr == $past(dcr))
        else $error("locked write changed spurious or debug register");
    AST_SRC_LOW: assert property (
        EXT_SRC[0] && smr[0][`ICTL_TRIG_MSB:`ICTL_TRIG_LSB] == 2'h0
        |-> pend[0] == !src_q[0])
        else $error("pin source code 0 is not low-level");
    AST_SRC_HIGH: assert property (
        smr[0][`ICTL_TRIG_MSB:`ICTL_TRIG_LSB] == 2'h2 |-> pend[0] == src_q[0])
        else $error("code 2 source is not high-level");
    AST_INT_RISE: assert property (
        !EXT_SRC[5] && smr[5][`ICTL_TRIG_LSB] && $rose(src_q[5]) |=> edge_pend[5])
        else $error("internal rising edge missed");
    AST_CUR_ID: assert property (
        ack |=> cur_id == $past(sel))
        else $error("acknowledge did not record the current source");

endmodule : ictl_top

`default_nettype wire

//--- sim/ictl_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// Core-side bus master: one transfer at a time, no byte lanes
module ictl_core_model (
    input  wire logic        pclk,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [31:0] paddr,
    output var  logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready
);
    // Idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 32'h00000000;
        pwdata  = 32'h00000000;
    end

    // Setup waits its own edge, so back-to-back calls never drive twice at once
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        // Judge completion at the rising edge itself, with the pre-edge values
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : ictl_core_model

`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ictl_map.svh"

module tb;
    localparam logic [31:0] BASE = `ICTL_BASE;
    logic        pclk = 1'b0;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] src_in;
    logic        irq_n;
    logic        fiq_n;
    logic        irq_out;
    logic [31:0] w;
    int          n_errors;
    int          total_checks;
    int          cycles = 0;
    logic [11:0] prot_off [4] = '{12'h00C, 12'h08C, `ICTL_OFF_SPU, `ICTL_OFF_DCR};

    ictl_top ictl_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_in(src_in), .irq_n(irq_n), .fiq_n(fiq_n), .irq_out(irq_out));

    ictl_core_model ictl_core_model_i (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

    ////////////////////////////////////////////////////////////////
    // Clock and hang guard; ceiling far above the roughly 950 cycles needed
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Comparisons and register access
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic wr(input logic [11:0] off, input logic [31:0] d);
        logic [31:0] unused;
        ictl_core_model_i.xfer(1'b1, BASE + {20'h0, off}, d, unused);
    endtask : wr
    task automatic rd(input logic [11:0] off, output logic [31:0] d);
        ictl_core_model_i.xfer(1'b0, BASE + {20'h0, off}, 32'h0, d);
    endtask : rd
    task automatic rchk(input logic [11:0] off, input logic [31:0] exp);
        logic [31:0] d;
        rd(off, d);
        chk_word(d, exp);
    endtask : rchk
    task automatic settle();
        repeat (4) @(posedge pclk);
    endtask : settle

    // Drive a source active then idle; edge codes must keep the latch, level codes not
    task automatic trig_case(input int s, input logic [1:0] code, input logic act);
        logic [31:0] d;
        src_in[s] <= ~act;
        wr(12'(s * 4), {25'h0, code, 5'h0});
        wr(`ICTL_OFF_ICCR, 32'h1 << s);
        src_in[s] <= act;
        settle();
        rd(`ICTL_OFF_IPR, d);
        chk_bit(d[s], 1'b1);
        src_in[s] <= ~act;
        settle();
        rd(`ICTL_OFF_IPR, d);
        chk_bit(d[s], code[0]);
        wr(`ICTL_OFF_ICCR, 32'h1 << s);
    endtask : trig_case

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////
    // Main sequence; source 0 held low through reset so it comes up pending
    initial begin
        presetn = 1'b0;
        src_in = 32'h00000000;
        n_errors = 0;
        total_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 64; i++) rchk(12'(i * 4), 32'h0);
        rchk(`ICTL_OFF_IPR, 32'h00000001);
        rchk(`ICTL_OFF_IMR, 32'h0);
        rchk(`ICTL_OFF_WPSR, 32'h0);
        // Locked writes are dropped and reported, event masked at first
        wr(`ICTL_OFF_WPMR, 32'h00000001);
        foreach (prot_off[k]) begin
            wr(prot_off[k], 32'hFFFFFFFF);
            rchk(prot_off[k], 32'h0);
            rchk(`ICTL_OFF_WPSR, {12'h0, prot_off[k], 7'h0, 1'b1});
            rd(`ICTL_OFF_WPSR, w);
            chk_bit(w[0], 1'b0);
            chk_bit(irq_out, 1'b0);
        end
        wr(`ICTL_OFF_EVM, 32'h00000001);
        settle();
        chk_bit(irq_out, 1'b1);
        rchk(`ICTL_OFF_EVS, 32'h00000001);
        settle();
        chk_bit(irq_out, 1'b0);
        wr(`ICTL_OFF_WPMR, 32'h0);
        // Handler addresses and mode fields; only mode bits 6:5 and 2:0 exist
        for (int i = 0; i < 32; i++) begin
            wr(12'(i * 4), 32'hFFFFFFFF);
            wr(12'(128 + i * 4), 32'hA5000000 | i);
        end
        for (int i = 0; i < 32; i++) begin
            rchk(12'(i * 4), `ICTL_SMR_MASK);
            rchk(12'(128 + i * 4), 32'hA5000000 | i);
        end
        // Reserved and out-of-window places
        wr(12'h118, 32'hFFFFFFFF);
        chk_bit(pslverr, 1'b0);
        rchk(12'h118, 32'h0);
        rchk(12'h13C, 32'h0);
        rchk(12'h1EC, 32'h0);
        ictl_core_model_i.xfer(1'b1, BASE - 32'h00000F80, 32'h0, w);
        rchk(`ICTL_OFF_SVR, 32'hA5000000);
        ictl_core_model_i.xfer(1'b0, BASE - 32'h00000F80, 32'h0, w);
        chk_word(w, 32'h0);
        // Every trigger code on an internal and on the pin source
        for (int c = 0; c < 4; c++) trig_case(5, 2'(c), 1'b1);
        for (int c = 0; c < 4; c++) trig_case(0, 2'(c), c[1]);
        // Priority pick and vectors
        wr(`ICTL_OFF_SPU, 32'h5A5A0000);
        wr(`ICTL_OFF_IECR, 32'h00000061);
        wr(12'h014, 32'h00000040);
        wr(12'h018, 32'h00000047);
        src_in[6:5] <= 2'b11;
        settle();
        chk_bit(irq_n, 1'b0);
        rchk(`ICTL_OFF_IVR, 32'hA5000006);
        rchk(`ICTL_OFF_ISR, 32'h00000006);
        wr(12'h014, 32'h00000047);
        wr(12'h018, 32'h00000040);
        settle();
        rchk(`ICTL_OFF_IVR, 32'hA5000005);
        // Protect mode: only an IVR write acknowledges; general mask silences irq_n
        wr(`ICTL_OFF_DCR, 32'h00000003);
        wr(12'h014, 32'h00000040);
        wr(12'h018, 32'h00000047);
        settle();
        chk_bit(irq_n, 1'b1);
        rchk(`ICTL_OFF_IVR, 32'hA5000006);
        rchk(`ICTL_OFF_ISR, 32'h00000005);
        wr(`ICTL_OFF_IVR, 32'h0);
        rchk(`ICTL_OFF_ISR, 32'h00000006);
        wr(`ICTL_OFF_DCR, 32'h0);
        src_in[6:5] <= 2'b00;
        settle();
        rchk(`ICTL_OFF_IVR, 32'h5A5A0000);
        // Fast source ignores its priority field
        wr(12'h000, 32'h00000040);
        src_in[0] <= 1'b1;
        settle();
        chk_bit(fiq_n, 1'b0);
        chk_bit(irq_n, 1'b1);
        rchk(`ICTL_OFF_FVR, 32'hA5000000);
        src_in[0] <= 1'b0;
        settle();
        rchk(`ICTL_OFF_FVR, 32'h5A5A0000);
        print_verdict();
    end
endmodule : tb

`default_nettype wire
